//--- src/axis_regs_pkg.sv
// constants, field layout and carrier types of the axis configuration/status bytes
package axis_regs_pkg;

  // byte positions on the host interface
  localparam logic [2:0] POS_CONFIG = 3'h3;
  localparam logic [2:0] POS_STATUS_OUT = 3'h5;
  localparam logic [2:0] POS_STATUS_ERR = 3'h6;
  localparam logic [2:0] POS_STATUS_SPARE = 3'h7;

  // configuration byte fields
  localparam int CFG_LAMP_BIT = 0;
  localparam int CFG_CODE_LSB = 1;
  localparam int CFG_GATE_SRC_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [2:0] GATE_CODE_MAX = 3'h4;

  // status byte 5 fields (digital outputs sit in bits 3..0)
  localparam int ST_SYNC_BIT = 4;
  localparam int ST_CMP1_BIT = 5;
  localparam int ST_CMP2_BIT = 6;
  localparam int ST_REF_BIT = 7;

  // status byte 6 error fields
  localparam int ERR_ADD_OVF_BIT = 0;
  localparam int ERR_WIRE_BIT = 1;
  localparam int ERR_OVERLOAD_BIT = 2;
  localparam int ERR_SSI_BIT = 3;
  localparam int ERR_EDGE_BIT = 4;
  localparam int ERR_UNSYNC_BIT = 5;
  localparam int ERR_CONFLICT_BIT = 6;
  localparam int ERR_DIR_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ssi frame framing levels
  localparam logic SSI_START_LEVEL = 1'b1;
  localparam logic SSI_STOP_LEVEL = 1'b0;

  // times, in their own units, and their cycle counts at the core clock
  localparam longint CLK_MHZ = 200;
  localparam longint CYC_PER_US = CLK_MHZ;
  localparam longint SLOW_MS_1 = 31;
  localparam longint SLOW_MS_2 = 93;
  localparam longint SLOW_MS_3 = 218;
  localparam longint SLOW_MS_4 = 438;
  localparam longint GATE_US_0 = 31250;
  localparam longint GATE_US_1 = 62500;
  localparam longint GATE_US_2 = 125000;
  localparam longint GATE_US_3 = 250000;
  localparam longint GATE_US_4 = 500000;
  localparam longint SLOW_CYC_1 = SLOW_MS_1 * 1000 * CYC_PER_US;
  localparam longint SLOW_CYC_2 = SLOW_MS_2 * 1000 * CYC_PER_US;
  localparam longint SLOW_CYC_3 = SLOW_MS_3 * 1000 * CYC_PER_US;
  localparam longint SLOW_CYC_4 = SLOW_MS_4 * 1000 * CYC_PER_US;
  localparam longint GATE_CYC_0 = GATE_US_0 * CYC_PER_US;
  localparam longint GATE_CYC_1 = GATE_US_1 * CYC_PER_US;
  localparam longint GATE_CYC_2 = GATE_US_2 * CYC_PER_US;
  localparam longint GATE_CYC_3 = GATE_US_3 * CYC_PER_US;
  localparam longint GATE_CYC_4 = GATE_US_4 * CYC_PER_US;

  typedef struct packed {
    logic axis_sel;
    logic [2:0] pos;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [3:0] dig_out;
    logic rapid_motion;
    logic slow_motion;
    logic ctrl_enable;
    logic brake;
    logic axis_sync;
    logic compare1_hit;
    logic compare2_hit;
    logic ref_contact_in;
  } core_status_t;

  typedef struct packed {
    logic adder_ovf;
    logic wire_break;
    logic output_overload;
    logic ssi_frame_done;
    logic ssi_start_bit;
    logic ssi_stop_bit;
    logic edge_fault;
    logic pos_start_req;
    logic ref_approach_req;
    logic start_cmd;
  } err_event_t;

endpackage

//--- src/axis_config_status_regs.sv
// axis configuration byte, status byte pair with read-order locking, lamp and timers
//
// Behaviour
// - lamp enable 0 keeps the error LED dark and turns it off.
// - lamp enable 1 lights the LED whenever any error flag is set.
// - drive mode: interval code picks minimum slow-motion time; codes 4..7 equal.
// - timer gating: interval code picks gate period 31.25..500 ms; 5..7 undefined.
// - incremental encoder: bit 4 selects gate from contact input or timer.
// - status bytes 5..7 are read-only; writes ignored; selected by axis select.
// - status bytes refresh only after byte 5 then byte 6 are read.
// - byte 5: outputs 1-4, sync, compare hits, reference contact level.
// - byte 6: eight error flags, overflow through direction fault.
// - status bit reads 1 when its condition holds or error occurred.
// - ssi frame with wrong start or stop bit sets ssi error.
// - incremental edge error sets edge-fault flag.
// - positioning requested while unsynchronized sets unsynced flag.
// - reference approach with flying sync enabled sets conflict flag.
// - start with both comparisons already met sets direction fault.
// - drive mode: bits 0,1 show rapid/slow; outputs depend on analog module.
// - flying sync enable activates flying sync, and the gate only with an incremental encoder outside drive mode; else both inactive.
//   flying_sync_active_out follows the enable alone, whatever the encoder and mode; only the gate is restricted.
`timescale 1ns/10ps
module axis_config_status_regs
  import axis_regs_pkg::*;
#(
  parameter int CNT_W = 27,
  parameter longint SLOW_CYC_P1 = SLOW_CYC_1,
  parameter longint SLOW_CYC_P2 = SLOW_CYC_2,
  parameter longint SLOW_CYC_P3 = SLOW_CYC_3,
  parameter longint SLOW_CYC_P4 = SLOW_CYC_4,
  // gate periods double per code, so the longer ones follow the shortest by default
  parameter longint GATE_CYC_P0 = GATE_CYC_0,
  parameter longint GATE_CYC_P1 = 2 * GATE_CYC_P0,
  parameter longint GATE_CYC_P2 = 4 * GATE_CYC_P0,
  parameter longint GATE_CYC_P3 = 8 * GATE_CYC_P0,
  parameter longint GATE_CYC_P4 = 16 * GATE_CYC_P0
)
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // host byte interface
  input wire host_req_t host_req_in,
  output logic [7:0] host_rdata_out,
  // axis mode
  input wire logic drive_mode_in,
  input wire logic flying_sync_en_in,
  input wire logic ssi_encoder_in,
  input wire logic analog_module_in,
  // core state and error events
  input wire core_status_t core_in,
  input wire err_event_t events_in,
  // outputs to the axis
  output logic error_led_out,
  output logic [3:0] phys_dig_out,
  output logic flying_sync_active_out,
  output logic gate_enable_out,
  output logic gate_open_out,
  output logic gate_tick_out,
  output logic slow_min_done_out
);

  typedef enum {ST_LOAD, ST_HELD, ST_HALF} pair_state_t;

  pair_state_t pair_q;
  logic [4:0] cfg_q;
  logic [7:0] snap_out_q;
  logic [7:0] snap_err_q;
  logic [7:0] err_q;
  logic [7:0] err_new;
  logic [7:0] live_out;
  logic [7:0] rdata_q;
  logic led_q;
  logic [3:0] phys_q;
  logic [CNT_W-1:0] gate_cnt_q;
  logic [CNT_W-1:0] gate_len;
  logic gate_tick_q;
  logic gate_open_q;
  logic [CNT_W-1:0] slow_cnt_q;
  logic [CNT_W-1:0] slow_len;
  logic slow_prev_q;
  logic slow_done_q;
  logic wr_cfg;
  logic rd_out;
  logic rd_err;
  logic gate_timer_run;
  logic gate_path_en;
  logic [2:0] code;

  assign code = cfg_q[CFG_CODE_LSB +: 3];
  assign wr_cfg = host_req_in.axis_sel && host_req_in.wr && (host_req_in.pos == POS_CONFIG);
  assign rd_out = host_req_in.axis_sel && host_req_in.rd && (host_req_in.pos == POS_STATUS_OUT);
  assign rd_err = host_req_in.axis_sel && host_req_in.rd && (host_req_in.pos == POS_STATUS_ERR);

  // configuration byte; only bits 4..0 are held, the rest read back as zero
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      cfg_q <= CFG_RESET;
    else if (wr_cfg)
      cfg_q <= host_req_in.wdata[4:0];
  end

  // error events; the source conditions decide which flag an event raises
  always_comb
  begin
    err_new = '0;
    err_new[ERR_ADD_OVF_BIT] = events_in.adder_ovf;
    err_new[ERR_WIRE_BIT] = events_in.wire_break;
    err_new[ERR_OVERLOAD_BIT] = events_in.output_overload;
    err_new[ERR_SSI_BIT] = ssi_encoder_in && events_in.ssi_frame_done
      && ((events_in.ssi_start_bit != SSI_START_LEVEL)
      || (events_in.ssi_stop_bit != SSI_STOP_LEVEL));
    err_new[ERR_EDGE_BIT] = !ssi_encoder_in && events_in.edge_fault;
    err_new[ERR_UNSYNC_BIT] = events_in.pos_start_req && !core_in.axis_sync;
    err_new[ERR_CONFLICT_BIT] = events_in.ref_approach_req && flying_sync_en_in;
    err_new[ERR_DIR_BIT] = events_in.start_cmd && core_in.compare1_hit
      && core_in.compare2_hit;
  end

  // live byte 5
  always_comb
  begin
    live_out = '0;
    live_out[3:0] = core_in.dig_out;
    if (drive_mode_in)
    begin
      live_out[0] = core_in.rapid_motion;
      live_out[1] = core_in.slow_motion;
    end
    live_out[ST_SYNC_BIT] = core_in.axis_sync;
    live_out[ST_CMP1_BIT] = core_in.compare1_hit;
    live_out[ST_CMP2_BIT] = core_in.compare2_hit;
    live_out[ST_REF_BIT] = core_in.ref_contact_in;
  end

  // byte pair sequencing: capture, hold, wait for byte 6 after byte 5
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      pair_q <= ST_LOAD;
    else
    begin
      unique case (pair_q)
        ST_LOAD: pair_q <= ST_HELD;
        ST_HELD: if (rd_out) pair_q <= ST_HALF;
        ST_HALF: if (rd_err) pair_q <= ST_LOAD;
      endcase
    end
  end

  // snapshot only moves in ST_LOAD, so the host always sees a matched pair
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      snap_out_q <= STATUS_RESET;
      snap_err_q <= STATUS_RESET;
    end
    else if (pair_q == ST_LOAD)
    begin
      snap_out_q <= live_out;
      snap_err_q <= err_q | err_new;
    end
  end

  // sticky errors between snapshots; a flag arriving on capture is kept for the next
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      err_q <= STATUS_RESET;
    else if (pair_q == ST_LOAD)
      err_q <= err_new;
    else
      err_q <= err_q | err_new;
  end

  // read data; writes to the status positions fall through untouched
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      rdata_q <= '0;
    else if (host_req_in.axis_sel && host_req_in.rd)
    begin
      unique case (host_req_in.pos)
        POS_CONFIG: rdata_q <= ssi_encoder_in ? {4'h0, cfg_q[3:0]} : {3'h0, cfg_q};
        POS_STATUS_OUT: rdata_q <= snap_out_q;
        POS_STATUS_ERR: rdata_q <= snap_err_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  // lamp follows pending and reported errors, gated by the enable bit
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      led_q <= 1'b0;
    else
      led_q <= cfg_q[CFG_LAMP_BIT] && ((|snap_err_q) || (|err_q));
  end

  // physical outputs; in drive mode outputs 1 and 2 carry rapid/slow, or enable/brake with the analog module
  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      phys_q <= '0;
    else if (drive_mode_in && analog_module_in)
      phys_q <= {core_in.dig_out[3:2], core_in.brake, core_in.ctrl_enable};
    else if (drive_mode_in)
      phys_q <= {core_in.dig_out[3:2], core_in.slow_motion, core_in.rapid_motion};
    else
      phys_q <= core_in.dig_out;
  end

  // gate timer period
  always_comb
  begin
    unique case (code)
      3'h0: gate_len = CNT_W'(GATE_CYC_P0);
      3'h1: gate_len = CNT_W'(GATE_CYC_P1);
      3'h2: gate_len = CNT_W'(GATE_CYC_P2);
      3'h3: gate_len = CNT_W'(GATE_CYC_P3);
      default: gate_len = CNT_W'(GATE_CYC_P4);
    endcase
  end

  // undefined codes leave the timer gate stopped rather than guessing a period
  assign gate_path_en = flying_sync_en_in && !ssi_encoder_in && !drive_mode_in;
  assign gate_timer_run = gate_path_en && cfg_q[CFG_GATE_SRC_BIT]
    && (code <= GATE_CODE_MAX);

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      gate_cnt_q <= '0;
      gate_tick_q <= 1'b0;
    end
    else if (!gate_timer_run)
    begin
      gate_cnt_q <= '0;
      gate_tick_q <= 1'b0;
    end
    else if (gate_cnt_q == '0)
    begin
      gate_cnt_q <= gate_len - CNT_W'(1);
      gate_tick_q <= 1'b1;
    end
    else
    begin
      gate_cnt_q <= gate_cnt_q - CNT_W'(1);
      gate_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
      gate_open_q <= 1'b0;
    else if (!gate_path_en)
      gate_open_q <= 1'b0;
    else if (cfg_q[CFG_GATE_SRC_BIT])
      gate_open_q <= gate_timer_run;
    else
      gate_open_q <= core_in.ref_contact_in;
  end

  // minimum slow-motion time
  always_comb
  begin
    unique case (code)
      3'h0: slow_len = '0;
      3'h1: slow_len = CNT_W'(SLOW_CYC_P1);
      3'h2: slow_len = CNT_W'(SLOW_CYC_P2);
      3'h3: slow_len = CNT_W'(SLOW_CYC_P3);
      default: slow_len = CNT_W'(SLOW_CYC_P4);
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!reset_n_in)
    begin
      slow_prev_q <= 1'b0;
      slow_cnt_q <= '0;
      slow_done_q <= 1'b0;
    end
    else
    begin
      slow_prev_q <= core_in.slow_motion;
      if (!drive_mode_in || !core_in.slow_motion)
      begin
        slow_cnt_q <= '0;
        slow_done_q <= 1'b0;
      end
      else if (!slow_prev_q)
      begin
        slow_cnt_q <= slow_len;
        slow_done_q <= (slow_len == '0);
      end
      else if (slow_cnt_q > CNT_W'(1))
      begin
        slow_cnt_q <= slow_cnt_q - CNT_W'(1);
        slow_done_q <= 1'b0;
      end
      else
      begin
        slow_cnt_q <= '0;
        slow_done_q <= 1'b1;
      end
    end
  end

  assign host_rdata_out = rdata_q;
  assign error_led_out = led_q;
  assign phys_dig_out = phys_q;
  assign flying_sync_active_out = flying_sync_en_in;
  assign gate_enable_out = gate_path_en;
  assign gate_open_out = gate_open_q;
  assign gate_tick_out = gate_tick_q;
  assign slow_min_done_out = slow_done_q;

  AST_LAMP_OFF: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !cfg_q[CFG_LAMP_BIT] |=> !error_led_out)
    else $error("error lamp lit while disabled");

  AST_LAMP_ON: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (cfg_q[CFG_LAMP_BIT] && (|err_q)) |=> error_led_out)
    else $error("error lamp dark with pending error");

  AST_CFG_WRITE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wr_cfg |=> (cfg_q == $past(host_req_in.wdata[4:0])))
    else $error("configuration write not stored");

  AST_STATUS_RO: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (pair_q != ST_LOAD) |=> $stable(snap_err_q) && $stable(snap_out_q))
    else $error("status snapshot changed outside capture");

  AST_PAIR_ORDER: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (pair_q == ST_HELD && rd_err) |=> (pair_q == ST_HELD))
    else $error("byte 6 read without byte 5 released the pair");

  AST_PAIR_RELEASE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (pair_q == ST_HALF && rd_err) |=> (pair_q == ST_LOAD) ##1 (pair_q == ST_HELD))
    else $error("pair not refreshed after ordered read");

  AST_UNSYNC_FLAG: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (events_in.pos_start_req && !core_in.axis_sync) |=> err_q[ERR_UNSYNC_BIT])
    else $error("unsynchronized positioning not flagged");

  AST_DIR_FLAG: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (events_in.start_cmd && core_in.compare1_hit && core_in.compare2_hit)
      |=> err_q[ERR_DIR_BIT])
    else $error("direction fault not flagged");

  AST_GATE_OFF: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !flying_sync_en_in |=> !gate_open_out && !gate_tick_out)
    else $error("gate active without flying sync");

endmodule // axis_config_status_regs

//--- test/axis_host_model.sv
// host controller model that drives the byte interface of one axis
`timescale 1ns/10ps
module axis_host_model
  import axis_regs_pkg::*;
(
  // clock
  input wire logic clk_in,
  // byte interface
  input wire logic [7:0] rdata_in,
  output host_req_t req_out
);
  initial req_out = '0;

  // a released bus shows inverted data, so stale values cannot pass for live ones
  task automatic release_bus();
    @(posedge clk_in);
    #1;
    req_out.wr = 1'b0;
    req_out.rd = 1'b0;
    req_out.axis_sel = 1'b0;
    req_out.wdata = ~req_out.wdata;
  endtask

  // unused upper configuration bits are always written as zero
  task automatic wr(input logic [2:0] pos, input logic [7:0] d, input logic ssi);
    @(posedge clk_in);
    #1;
    req_out = '{1'b1, pos, 1'b1, 1'b0, d & (ssi ? 8'h0F : 8'h1F)};
    release_bus();
  endtask

  task automatic rd(input logic [2:0] pos, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    req_out = '{1'b1, pos, 1'b0, 1'b1, 8'h00};
    release_bus();
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask

  // the status pair is always read low byte first
  task automatic pair(output logic [7:0] b5, output logic [7:0] b6);
    rd(POS_STATUS_OUT, b5);
    rd(POS_STATUS_ERR, b6);
  endtask
endmodule // axis_host_model

//--- test/axis_config_status_regs_tb.sv
// self-checking bench for the axis configuration and status bytes
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, a, e); end end
module axis_config_status_regs_tb
  import axis_regs_pkg::*;
;
  localparam int SLOW_T[5] = '{0, 10, 20, 30, 40};
  localparam int GATE_T[5] = '{8, 16, 32, 64, 128};
  int fail_count = 0;
  int checks_done = 0;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  host_req_t req;
  logic [7:0] rdata;
  logic drive_mode = 1'b0;
  logic fly_en = 1'b0;
  logic ssi_enc = 1'b0;
  logic analog = 1'b0;
  core_status_t core = 12'hA0B;
  err_event_t ev = '0;
  logic led;
  logic [3:0] phys;
  logic fly_act;
  logic gate_en;
  logic gate_open;
  logic gate_tick;
  logic slow_done;
  logic [7:0] b5;
  logic [7:0] b6;
  logic [7:0] rv;
  int n;

  always #2.5 ref_clk = ~ref_clk;

  // short counts keep the timer scenarios within a few thousand cycles;
  // the longer gate periods follow from the shortest one by doubling
  axis_config_status_regs #(
    .SLOW_CYC_P1(10), .SLOW_CYC_P2(20), .SLOW_CYC_P3(30), .SLOW_CYC_P4(40),
    .GATE_CYC_P0(8)
  ) dut (
    .ref_clk_in(ref_clk), .reset_n_in(reset_n), .host_req_in(req),
    .host_rdata_out(rdata), .drive_mode_in(drive_mode), .flying_sync_en_in(fly_en),
    .ssi_encoder_in(ssi_enc), .analog_module_in(analog), .core_in(core),
    .events_in(ev), .error_led_out(led), .phys_dig_out(phys),
    .flying_sync_active_out(fly_act), .gate_enable_out(gate_en),
    .gate_open_out(gate_open), .gate_tick_out(gate_tick), .slow_min_done_out(slow_done)
  );

  axis_host_model host (.clk_in(ref_clk), .rdata_in(rdata), .req_out(req));

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // cycles until the next gate tick, 300 when none comes
  task automatic wait_tick(output int k);
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (gate_tick !== 1'b1 && k < 300);
  endtask

  // first pair read hands the event to the snapshot, the second shows it
  task automatic err_case(input logic ssi, input err_event_t e, input logic [7:0] exp);
    ssi_enc = ssi;
    ev = e;
    tick(1);
    ev = '0;
    host.pair(b5, b6);
    host.pair(b5, b6);
    `CHK(b6, exp)
  endtask

  initial
  begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    tick(12);
    reset_n = 1'b1;
    host.rd(POS_CONFIG, rv);
    `CHK(rv, 8'h00)
    `CHK(led, 1'b0)
    host.wr(POS_CONFIG, 8'hFF, 1'b0);
    host.rd(POS_CONFIG, rv);
    `CHK(rv, 8'h1F)
    ssi_enc = 1'b1;
    host.rd(POS_CONFIG, rv);
    `CHK(rv, 8'h0F)
    ssi_enc = 1'b0;
    host.pair(b5, b6);
    `CHK(b5, 8'hDA)
    `CHK(b6, 8'h00)
    for (int p = 5; p < 8; p++)
      host.wr(3'(p), 8'h1F, 1'b0);
    host.pair(b5, b6);
    `CHK(b5, 8'hDA)
    `CHK(b6, 8'h00)
    host.rd(POS_STATUS_SPARE, rv);
    `CHK(rv, 8'h00)
    host.rd(3'h2, rv);
    `CHK(rv, 8'h00)
    // freeze from byte 5 read until byte 6 read, stray byte 6 reads release nothing
    host.rd(POS_STATUS_OUT, b5);
    core.dig_out = 4'h5;
    host.rd(POS_STATUS_OUT, b5);
    `CHK(b5, 8'hDA)
    host.rd(POS_STATUS_ERR, b6);
    host.rd(POS_STATUS_ERR, b6);
    core.dig_out = 4'h3;
    host.rd(POS_STATUS_ERR, b6);
    host.pair(b5, b6);
    `CHK(b5, 8'hD5)
    host.pair(b5, b6);
    `CHK(b5, 8'hD3)
    // lamp follows error flags only while enabled
    `CHK(led, 1'b0)
    ev = 10'h200;
    tick(1);
    ev = '0;
    tick(2);
    `CHK(led, 1'b1)
    host.wr(POS_CONFIG, 8'h1E, 1'b0);
    tick(2);
    `CHK(led, 1'b0)
    host.wr(POS_CONFIG, 8'h1F, 1'b0);
    tick(2);
    `CHK(led, 1'b1)
    host.pair(b5, b6);
    host.pair(b5, b6);
    tick(2);
    `CHK(led, 1'b0)
    // drive mode output mapping
    `CHK(fly_act, 1'b0)
    core = 12'hC9B;
    drive_mode = 1'b1;
    tick(2);
    `CHK(phys, 4'hD)
    analog = 1'b1;
    tick(2);
    `CHK(phys, 4'hE)
    host.pair(b5, b6);
    host.pair(b5, b6);
    `CHK(b5, 8'hDD)
    // minimum slow-motion time, codes 0..3 and code 7 timed as code 4
    foreach (SLOW_T[i])
    begin
      host.wr(POS_CONFIG, 8'(((i == 0) ? 7 : i - 1) << 1), 1'b0);
      core.slow_motion = 1'b1;
      n = 0;
      while (slow_done !== 1'b1 && n < 200)
      begin
        tick(1);
        n++;
      end
      rv = 8'(SLOW_T[(i == 0) ? 4 : i - 1]);
      `CHK((n >= rv && n <= rv + 1) || (rv == 0 && n == 1), 1'b1)
      core.slow_motion = 1'b0;
      tick(2);
      `CHK(slow_done, 1'b0)
    end
    drive_mode = 1'b0;
    analog = 1'b0;
    tick(2);
    `CHK(phys, 4'hC)
    // gate from reference contact, then from the timer
    fly_en = 1'b1;
    host.wr(POS_CONFIG, 8'h00, 1'b0);
    tick(2);
    `CHK(fly_act, 1'b1)
    `CHK(gate_en, 1'b1)
    `CHK(gate_open, 1'b1)
    core.ref_contact_in = 1'b0;
    tick(2);
    `CHK(gate_open, 1'b0)
    for (int c = 0; c < 7; c++)
    begin
      fly_en = (c != 6);
      host.wr(POS_CONFIG, 8'h10 | 8'((c % 6) << 1), 1'b0);
      wait_tick(n);
      wait_tick(n);
      `CHK(n, (c < 5) ? GATE_T[c] : 300)
      `CHK(gate_open, (c < 5) ? 1'b1 : 1'b0)
    end
    // error flags, each in turn, with the axis unsynchronised and both comparisons met
    core = 12'h006;
    err_case(1'b0, 10'h200, 8'h01);
    err_case(1'b0, 10'h100, 8'h02);
    err_case(1'b0, 10'h080, 8'h04);
    err_case(1'b1, 10'h040, 8'h08);
    err_case(1'b1, 10'h070, 8'h08);
    err_case(1'b1, 10'h060, 8'h00);
    err_case(1'b0, 10'h008, 8'h10);
    err_case(1'b0, 10'h004, 8'h20);
    // the conflict needs flying sync requested alongside the reference approach
    fly_en = 1'b1;
    err_case(1'b0, 10'h002, 8'h40);
    err_case(1'b0, 10'h001, 8'h80);
    give_verdict();
  end
endmodule // axis_config_status_regs_tb
